/* File: hdl/asm_defs.vh */
/*
  Constants for the asynchronous static-memory timing controller:
  register byte offsets, field positions and reset values.
  Assumes inclusion by the controller and its bench; definitions only.
*/
`ifndef ASM_DEFS_VH
`define ASM_DEFS_VH

// register byte offsets on the AXI4-Lite bus
`define ASM_OFS_CTRL        4'h0
`define ASM_OFS_RTIM        4'h4
`define ASM_OFS_WTIM        4'h8
`define ASM_OFS_STAT        4'hC

// bank_control fields
`define ASM_CTL_BANK_EN     0
`define ASM_CTL_MUX_EN      1
`define ASM_CTL_MEMORY_TYPE_LO     2
`define ASM_CTL_MEMORY_TYPE_HI     3
`define ASM_CTL_FACC_EN     6
`define ASM_CTL_BURST_EN    8
`define ASM_CTL_WAIT_POL    9
`define ASM_CTL_EXT_MODE    14
`define ASM_CTL_ASYNC_WAIT  15

// timing register fields
`define ASM_TIM_ADDR_SETUP_CYCLES_LO   0
`define ASM_TIM_ADDR_SETUP_CYCLES_HI   3
`define ASM_TIM_DATA_PHASE_CYCLES_LO   8
`define ASM_TIM_DATA_PHASE_CYCLES_HI   15
`define ASM_TIM_ACCESS_MODE_FIELD_LO   28
`define ASM_TIM_ACCESS_MODE_FIELD_HI   29

// access-mode field encodings
`define ASM_ACC_MODE_A      2'h0
`define ASM_ACC_MODE_B      2'h1
`define ASM_ACC_MODE_C      2'h2

// reset values
`define ASM_CTRL_RESET      32'h0000_0000
`define ASM_RTIM_RESET      32'h0000_FF0F
`define ASM_WTIM_RESET      32'h0000_FF0F

// AXI responses
`define ASM_RESP_OKAY       2'h0
`define ASM_RESP_DECERR     2'h3

`endif

/* File: hdl/asm_ctrl.v */
/*
  Asynchronous static-memory controller (SRAM, PSRAM, non-multiplexed
  NOR flash), timing modes 2, A, B and C, with an AXI4-Lite register slave.
  Assumes one clock aclk, synchronous active-low aresetn, memory pins and
  the wait input sampled as synchronous to aclk; no clock goes to memory.
*/
`timescale 1ns/10ps
`include "asm_defs.vh"

module asm_ctrl #(
  parameter AW = 24,
  parameter DW = 16
) (
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite slave
  input  wire [3:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [3:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // internal access request and response
  input  wire          mem_req_valid,
  output wire          mem_req_ready,
  input  wire          mem_req_write,
  input  wire [AW-1:0] mem_req_addr,
  input  wire [DW-1:0] mem_req_wdata,
  input  wire [1:0]    mem_req_be,
  output reg           mem_rsp_valid,
  output reg  [DW-1:0] mem_rsp_rdata,
  // memory pins
  output reg           bank_select_n,
  output reg           read_strobe_n,
  output reg           write_strobe_n,
  output reg           address_valid_strobe_n,
  output reg  [1:0]    byte_lane_select_n,
  output reg  [AW-1:0] mem_addr,
  output reg  [DW-1:0] mem_dq_o,
  output reg           mem_dq_oe,
  input  wire [DW-1:0] mem_dq_i,
  input  wire          mem_wait
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [31:0]   ctrl_reg;
  reg [31:0]   rtim_reg;
  reg [31:0]   wtim_reg;
  reg          aw_have_reg;
  reg [3:0]    aw_addr_reg;
  reg          w_have_reg;
  reg [31:0]   w_data_reg;
  reg [3:0]    w_strb_reg;

  reg [1:0]    state_reg;
  reg [1:0]    state_next;
  reg [8:0]    cnt_reg;
  reg [8:0]    cnt_next;
  reg [8:0]    dcnt_reg;
  reg          wr_reg;
  reg          oe_pulse_reg;
  reg          adv_pulse_reg;
  reg [1:0]    be_reg;
  reg [1:0]    last_mode_reg;

  // merge written bytes into a register under the strobes
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          wmerge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // register file decode shared by read and write paths
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `ASM_OFS_CTRL) || (a == `ASM_OFS_RTIM) ||
               (a == `ASM_OFS_WTIM) || (a == `ASM_OFS_STAT);
    end
  endfunction

  // AXI4-Lite write channel: address and data accepted in either order
  wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg  <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_have_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ASM_RESP_OKAY;
      ctrl_reg     <= `ASM_CTRL_RESET;
      rtim_reg     <= `ASM_RTIM_RESET;
      wtim_reg     <= `ASM_WTIM_RESET;
    end else begin
      if (s_axi_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? `ASM_RESP_OKAY
                                            : `ASM_RESP_DECERR;
        case (aw_addr_reg)
          `ASM_OFS_CTRL: ctrl_reg <= wmerge(ctrl_reg, w_data_reg, w_strb_reg);
          `ASM_OFS_RTIM: rtim_reg <= wmerge(rtim_reg, w_data_reg, w_strb_reg);
          `ASM_OFS_WTIM: wtim_reg <= wmerge(wtim_reg, w_data_reg, w_strb_reg);
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire [31:0] stat_word = {28'h0000000, last_mode_reg,
                           state_reg != ST_IDLE, ctrl_reg[`ASM_CTL_EXT_MODE]};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ASM_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped({s_axi_araddr[3:2], 2'h0}) ? `ASM_RESP_OKAY
                                                        : `ASM_RESP_DECERR;
      case ({s_axi_araddr[3:2], 2'h0})
        `ASM_OFS_CTRL: s_axi_rdata <= ctrl_reg;
        `ASM_OFS_RTIM: s_axi_rdata <= rtim_reg;
        `ASM_OFS_WTIM: s_axi_rdata <= wtim_reg;
        `ASM_OFS_STAT: s_axi_rdata <= stat_word;
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // timing selection for the request being offered
  wire       ext_mode = ctrl_reg[`ASM_CTL_EXT_MODE];
  // write timing register ignored entirely unless extended
  wire [31:0] tim_sel = (mem_req_write && ext_mode) ? wtim_reg : rtim_reg;
  wire [1:0] acc_mode = tim_sel[`ASM_TIM_ACCESS_MODE_FIELD_HI:`ASM_TIM_ACCESS_MODE_FIELD_LO];
  wire [3:0] addr_setup_cycles   = tim_sel[`ASM_TIM_ADDR_SETUP_CYCLES_HI:`ASM_TIM_ADDR_SETUP_CYCLES_LO];
  wire [7:0] data_phase_cycles   = tim_sel[`ASM_TIM_DATA_PHASE_CYCLES_HI:`ASM_TIM_DATA_PHASE_CYCLES_LO];
  // read strobe toggles only in modes A and C
  wire oe_pulse  = ext_mode && (acc_mode == `ASM_ACC_MODE_A ||
                                acc_mode == `ASM_ACC_MODE_C);
  // address-valid pulses in modes 2, B and C
  wire adv_pulse = !ext_mode || (acc_mode != `ASM_ACC_MODE_A);

  // a zero count still gives one cycle so the access cannot hang
  wire [8:0] addr_cycles = (addr_setup_cycles == 4'h0) ? 9'h001 : {5'h00, addr_setup_cycles};
  wire [8:0] data_cycles = mem_req_write ? ({1'b0, data_phase_cycles} + 9'h001)
                         : ((data_phase_cycles == 8'h00) ? 9'h001
                                              : {1'b0, data_phase_cycles});

  // wait is only honoured when enabled; polarity has no effect otherwise
  wire wait_on = ctrl_reg[`ASM_CTL_ASYNC_WAIT] &&
                 (mem_wait == ctrl_reg[`ASM_CTL_WAIT_POL]);

  assign mem_req_ready = (state_reg == ST_IDLE) &&
                         ctrl_reg[`ASM_CTL_BANK_EN];
  wire start = mem_req_valid && mem_req_ready;

  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_ADDR;
          cnt_next   = addr_cycles;
        end
      end
      ST_ADDR: begin
        // address phase is never stretched by wait
        if (cnt_reg == 9'h001) begin
          state_next = ST_DATA;
          cnt_next   = dcnt_reg;
        end else begin
          cnt_next = cnt_reg - 9'h001;
        end
      end
      ST_DATA: begin
        if (wait_on) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg == 9'h001) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 9'h001;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = 9'h000;
      end
    endcase
  end

  wire last_data = (state_reg == ST_DATA) && !wait_on &&
                   (cnt_reg == 9'h001);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 9'h000;
      dcnt_reg      <= 9'h000;
      wr_reg        <= 1'b0;
      oe_pulse_reg  <= 1'b0;
      adv_pulse_reg <= 1'b0;
      be_reg        <= 2'h0;
      last_mode_reg <= 2'h0;
      mem_addr      <= {AW{1'b0}};
      mem_dq_o      <= {DW{1'b0}};
      mem_rsp_valid <= 1'b0;
      mem_rsp_rdata <= {DW{1'b0}};
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      mem_rsp_valid <= 1'b0;
      if (start) begin
        // timing and strobe settings are frozen per access; later register writes apply
        // from the next access on, except wait enable and polarity, which act at once
        dcnt_reg      <= data_cycles;
        wr_reg        <= mem_req_write;
        oe_pulse_reg  <= oe_pulse;
        adv_pulse_reg <= adv_pulse;
        // reads drive both byte lanes active
        be_reg        <= mem_req_write ? mem_req_be : 2'h3;
        last_mode_reg <= acc_mode;
        mem_addr      <= mem_req_addr;
        mem_dq_o      <= mem_req_wdata;
      end
      if (last_data) begin
        // sampled while bank select is still low
        mem_rsp_valid <= 1'b1;
        if (!wr_reg)
          mem_rsp_rdata <= mem_dq_i;
      end
    end
  end

  // pin levels follow the next state so every pin is a flip-flop
  wire       in_addr_next = (state_next == ST_ADDR);
  wire       in_data_next = (state_next == ST_DATA);
  wire       busy_next    = in_addr_next || in_data_next;
  wire       wr_next      = (state_reg == ST_IDLE) ? mem_req_write : wr_reg;
  wire       oep_next     = (state_reg == ST_IDLE) ? oe_pulse : oe_pulse_reg;
  wire       advp_next    = (state_reg == ST_IDLE) ? adv_pulse : adv_pulse_reg;
  wire [1:0] be_next      = (state_reg == ST_IDLE)
                          ? (mem_req_write ? mem_req_be : 2'h3) : be_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      bank_select_n          <= 1'b1;
      read_strobe_n          <= 1'b1;
      write_strobe_n         <= 1'b1;
      address_valid_strobe_n <= 1'b1;
      byte_lane_select_n     <= 2'h3;
      mem_dq_oe              <= 1'b0;
    end else begin
      bank_select_n          <= !busy_next;
      read_strobe_n          <= !(busy_next && !wr_next &&
                                  (in_data_next || !oep_next));
      // last write data cycle keeps strobe high for hold time
      write_strobe_n         <= !(in_data_next && wr_next &&
                                  cnt_next != 9'h001);
      address_valid_strobe_n <= !(in_addr_next && advp_next);
      byte_lane_select_n     <= busy_next ? ~be_next : 2'h3;
      mem_dq_oe              <= busy_next && wr_next;
    end
  end

endmodule

/* File: test/asm_ctrl_checker.sv */
/*
  Concurrent checks on the memory-side pins of asm_ctrl.
  Assumes it is bound to asm_ctrl and sees only its ports; one clock.
*/
`timescale 1ns/10ps
module asm_ctrl_checker (
  input wire       aclk,
  input wire       aresetn,
  input wire       mem_req_valid,
  input wire       mem_req_ready,
  input wire       mem_rsp_valid,
  input wire       bank_select_n,
  input wire       read_strobe_n,
  input wire       write_strobe_n,
  input wire       address_valid_strobe_n,
  input wire [1:0] byte_lane_select_n,
  input wire       mem_dq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take;
    mem_req_valid && mem_req_ready;
  endsequence
  sequence s_open;
    !bank_select_n && !mem_req_ready;
  endsequence
  property p_start;
    s_take |=> s_open;
  endproperty
  property p_busy;
    !bank_select_n |-> !mem_req_ready;
  endproperty
  property p_lanes;
    !read_strobe_n |-> byte_lane_select_n == 2'h0;
  endproperty
  property p_in_bank;
    !(read_strobe_n && write_strobe_n && address_valid_strobe_n)
      |-> !bank_select_n;
  endproperty
  property p_oe;
    !write_strobe_n |-> mem_dq_oe && read_strobe_n;
  endproperty
  property p_release;
    mem_rsp_valid |-> bank_select_n && $past(!bank_select_n);
  endproperty
  property p_we_late;
    $fell(write_strobe_n) |-> $past(!bank_select_n);
  endproperty
  property p_adv_end;
    $rose(address_valid_strobe_n) && !bank_select_n
      |-> !(read_strobe_n && write_strobe_n);
  endproperty
  a_start:   assert property (p_start)
    else $error("no bank after take");
  a_busy:    assert property (p_busy)
    else $error("ready while busy");
  a_lanes:   assert property (p_lanes)
    else $error("read lanes not low");
  a_in_bank: assert property (p_in_bank)
    else $error("strobe w/o bank");
  a_oe:      assert property (p_oe)
    else $error("write not driven");
  a_release: assert property (p_release)
    else $error("bank not released");
  a_we_late: assert property (p_we_late)
    else $error("no address phase");
  a_adv_end: assert property (p_adv_end)
    else $error("no data phase");
endmodule

bind asm_ctrl asm_ctrl_checker asm_ctrl_checker_i (
  .aclk, .aresetn, .mem_req_valid, .mem_req_ready, .mem_rsp_valid,
  .bank_select_n, .read_strobe_n, .write_strobe_n,
  .address_valid_strobe_n, .byte_lane_select_n, .mem_dq_oe
);

/* File: test/asm_mem_model.sv */
/*
  Behavioural 16-word asynchronous static memory with a wait output.
  Assumes pins come straight from asm_ctrl; wait asserted for the first wait_len cycles with bank select low and address valid high.
*/
`timescale 1ns/10ps
module asm_mem_model (
  input  wire        aclk,
  input  wire        bank_select_n,
  input  wire        read_strobe_n,
  input  wire        write_strobe_n,
  input  wire        address_valid_strobe_n,
  input  wire [1:0]  byte_lane_select_n,
  input  wire [23:0] mem_addr,
  input  wire [15:0] mem_dq_o,
  input  wire        wait_pol,
  input  wire [31:0] wait_len,
  output wire [15:0] mem_dq_i,
  output wire        mem_wait
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  integer      cnt = 0;
  wire         dph = !bank_select_n && address_valid_strobe_n;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  // cycles with bank select low and address valid high count, so in mode A the address phase counts too
  assign mem_wait = (dph && cnt < wait_len) ? wait_pol : !wait_pol;
  // released bus shows the inverse of the last word, never a stale match
  assign mem_dq_i = (!read_strobe_n && !bank_select_n) ?
                    mem[mem_addr[3:0]] : ~last;
  always @(posedge aclk) begin
    cnt <= dph ? cnt + 1 : 0;
    if (!read_strobe_n && !bank_select_n) last <= mem_dq_i;
    if (!write_strobe_n && !bank_select_n) begin
      if (!byte_lane_select_n[0]) mem[mem_addr[3:0]][7:0] <= mem_dq_o[7:0];
      if (!byte_lane_select_n[1]) mem[mem_addr[3:0]][15:8] <= mem_dq_o[15:8];
    end
  end
endmodule

/* File: test/tb.sv */
/*
  Self-checking bench for asm_ctrl: registers over AXI4-Lite, timed
  reads and writes against asm_mem_model in modes 2, A, B and C.
  Assumes asm_defs.vh on the include path.
*/
`timescale 1ns/10ps
`include "asm_defs.vh"
module tb;
  logic        aclk = 0, aresetn = 0, wait_pol = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, r, wait_len = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, mem_req_ready, mem_rsp_valid, mem_wait;
  wire [1:0]   s_axi_bresp, s_axi_rresp, byte_lane_select_n;
  wire [31:0]  s_axi_rdata;
  logic        mem_req_valid = 0, mem_req_write = 0, ext;
  logic [23:0] mem_req_addr = 0;
  logic [15:0] mem_req_wdata = 0, shadow [0:15];
  logic [1:0]  mem_req_be = 0, mr, mw;
  wire [15:0]  mem_rsp_rdata, mem_dq_o, mem_dq_i;
  wire [23:0]  mem_addr;
  wire         bank_select_n, read_strobe_n, write_strobe_n, mem_dq_oe;
  wire         address_valid_strobe_n;
  integer      seed = 84131, bad_count = 0, samples_checked = 0;
  integer      n [4], c, j, ar, dr, aw, dw;
  asm_ctrl asm_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req_valid,
    .mem_req_ready, .mem_req_write, .mem_req_addr, .mem_req_wdata,
    .mem_req_be, .mem_rsp_valid, .mem_rsp_rdata, .bank_select_n,
    .read_strobe_n, .write_strobe_n, .address_valid_strobe_n,
    .byte_lane_select_n, .mem_addr, .mem_dq_o, .mem_dq_oe, .mem_dq_i,
    .mem_wait);
  asm_mem_model asm_mem_model_i (.aclk, .bank_select_n, .read_strobe_n,
    .write_strobe_n, .address_valid_strobe_n, .byte_lane_select_n,
    .mem_addr, .mem_dq_o, .wait_pol, .wait_len, .mem_dq_i, .mem_wait);
  always #12.5 aclk = ~aclk;
  task chk(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // bready stays high between writes; only the watchdog ends a wait
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk(s_axi_bvalid, 1, "bvalid");
    chk(s_axi_bresp, `ASM_RESP_OKAY, "bresp");
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk(s_axi_rvalid, 1, "rvalid");
    chk(s_axi_rresp, `ASM_RESP_OKAY, "rresp");
  endtask
  // expected pin counts follow from mode, setup, data and wait cycles
  task acc(input logic w, input logic [1:0] md, input integer as, ds, wt);
    logic [3:0]  a;
    logic [15:0] d;
    logic [1:0]  be;
    integer      k;
    a = 4'($random(seed));
    d = 16'($random(seed));
    be = w ? 2'($random(seed)) : 2'h0;
    mem_req_write <= w;
    mem_req_addr <= {20'h0, a};
    mem_req_wdata <= d;
    mem_req_be <= be;
    mem_req_valid <= 1;
    k = 0;
    do begin @(posedge aclk); k++; end while (!mem_req_ready && k < 50);
    mem_req_valid <= 0;
    n = '{0, 0, 0, 0};
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      n[0] += !bank_select_n;
      n[1] += !read_strobe_n;
      n[2] += !write_strobe_n;
      n[3] += !address_valid_strobe_n;
    end while (!mem_rsp_valid && k < 400);
    chk(k, as + ds + wt + 1 + w, "latency");
    chk(n[0], as + ds + wt + w, "bank low");
    chk(n[3], md ? as : 0, "adv low");
    if (w) begin
      chk(n[2], ds, "write strobe");
      for (k = 0; k < 2; k++) if (be[k]) shadow[a][k*8+:8] = d[k*8+:8];
    end else begin
      chk(n[1], md == 2'h1 ? as + ds + wt : ds + wt, "read strobe");
      chk(mem_rsp_rdata, shadow[a], "read data");
    end
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    for (c = 0; c < 16; c++) shadow[c] = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`ASM_OFS_CTRL, r);
    chk(r, `ASM_CTRL_RESET, "ctrl reset");
    rd(`ASM_OFS_RTIM, r);
    chk(r, `ASM_RTIM_RESET, "rtim reset");
    rd(`ASM_OFS_WTIM, r);
    chk(r, `ASM_WTIM_RESET, "wtim reset");
    s_axi_wstrb <= 4'h1;
    wr(`ASM_OFS_RTIM, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    rd(`ASM_OFS_RTIM, r);
    chk(r, `ASM_RTIM_RESET | 32'h0000_00FF, "strobed write");
    chk(mem_req_ready, 0, "ready disabled");
    // c 0 is mode 2 with a junk write register, then A, B, C extended
    for (c = 0; c < 4; c++) for (j = 0; j < 4; j++) begin
      ext = c != 0;
      mr = c ? 2'(c - 1) : 2'h1;
      mw = ext && mr ? 2'(1 + {$random(seed)} % 2) : 2'h0;
      ar = j ? 1 + {$random(seed)} % 4 : 15;
      dr = j ? 1 + {$random(seed)} % 6 : 255;
      aw = 1 + {$random(seed)} % 4;
      dw = 1 + {$random(seed)} % 6;
      wr(`ASM_OFS_CTRL, {17'h0, ext, 7'h0, mr ? 7'h49 : 7'h01});
      wr(`ASM_OFS_RTIM, {2'h0, mr, 12'h0, 8'(dr), 4'h0, 4'(ar)});
      wr(`ASM_OFS_WTIM, {2'h0, mw, 12'h0, 8'(dw), 4'h0, 4'(aw)});
      acc(1, ext ? mw : 2'h1, ext ? aw : ar, ext ? dw : dr, 0);
      acc(0, mr, ar, dr, 0);
      rd(`ASM_OFS_STAT, r);
      chk(r[3:0], {mr, 1'b0, ext}, "status");
    end
    wr(`ASM_OFS_RTIM, {2'h0, 2'h2, 12'h0, 8'h03, 4'h0, 4'h2});
    // stretch, wrong polarity, then wait disabled with wait held active
    for (j = 0; j < 3; j++) begin
      wr(`ASM_OFS_CTRL, j < 2 ? 32'h0000_C249 : 32'h0000_4249);
      wait_pol <= j != 1;
      wait_len <= j ? 32'h0000_0064 : 32'h0000_0003;
      acc(0, 2'h2, 2, 3, j ? 0 : 3);
    end
    tally_and_finish;
  end
endmodule
